// [src/med_pkg.sv]
// package of register offsets, fields, reset values and timing for the motion event block
// assumes a host register port (address, write strobe, read strobe) from the serial interface
// Operation
// - x above and below flags report events
// - event source register ignores host writes
// - source read clears register and interrupt when latched
// - seven-bit threshold resets to two
// - threshold msb selects counter reset or decrement
// - fast rate step is 2.5 ms
// - slow rate step is 10 ms
// - latched confirmed event freezes the counter
// - latch enable holds source until read
// - combine select chooses or versus and
package med_pkg;
  // ==========================================
  // register map
  localparam logic [7:0] MED_CFG_OFS  = 8'h30;
  localparam logic [7:0] MED_SRC_OFS  = 8'h31;
  localparam logic [7:0] MED_THS_OFS  = 8'h32;
  localparam logic [7:0] MED_DUR_OFS  = 8'h33;
  localparam logic [7:0] MED_CFG_RST  = 8'h00;
  localparam logic [7:0] MED_THS_RST  = 8'h02;
  localparam logic [7:0] MED_DUR_RST  = 8'h00;
  localparam int         MED_COUNTER_DECREMENT_SELECT_BIT = 7;
  localparam int         MED_COMB_BIT = 7;
  localparam int         MED_LIR_BIT  = 6;
  localparam int         MED_IA_BIT   = 6;
  // ==========================================
  // timing, sample periods in microseconds
  localparam int MED_CLK_MHZ       = 250;
  localparam int MED_FAST_STEP_US  = 2500;
  localparam int MED_SLOW_STEP_US  = 10000;
  localparam int MED_FAST_CYC      = MED_FAST_STEP_US * MED_CLK_MHZ;
  localparam int MED_SLOW_CYC      = MED_SLOW_STEP_US * MED_CLK_MHZ;
  // ==========================================
  // types
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } med_bus_t;
  typedef enum logic [0:0] {MED_IDLE, MED_FIRED} med_state_t;
endpackage

// [src/med_tick.sv]
// sample tick generator: one pulse per output data sample
// assumes rate select is stable while counting
module med_tick #(
  parameter int FAST_CYC = med_pkg::MED_FAST_CYC,
  parameter int SLOW_CYC = med_pkg::MED_SLOW_CYC
) (
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  input  wire logic fast_in,
  output logic      tick_out
);
  logic [31:0] cnt_q;
  wire  [31:0] lim = fast_in ? 32'(FAST_CYC - 1) : 32'(SLOW_CYC - 1);
  wire         wrap = (cnt_q >= lim);
  // ==========================================
  // fast or slow step count, limit picked by fast_in
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      cnt_q    <= 32'h0000_0000;
      tick_out <= 1'b0;
    end
    else if (ce_in)
    begin
      cnt_q    <= wrap ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
      tick_out <= wrap;
    end
  end
endmodule

// [src/med_top.sv]
// motion event duration logic: config, source, threshold and duration registers
// assumes per-axis comparator results arrive synchronous and valid at each sample
module med_top #(
  parameter int FAST_CYC = med_pkg::MED_FAST_CYC,
  parameter int SLOW_CYC = med_pkg::MED_SLOW_CYC
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  input  wire logic             ce_in,
  input  wire med_pkg::med_bus_t bus_in,
  input  wire logic             fast_rate_in,
  input  wire logic [5:0]       axis_event_in,
  output logic      [7:0]       rdata_out,
  output logic      [6:0]       threshold_value_out,
  output logic                  motion_interrupt_out
);
  // ==========================================
  // storage and next values
  logic [7:0]          cfg_q;
  logic [7:0]          cfg_d;
  logic [7:0]          ths_q;
  logic [7:0]          ths_d;
  logic [7:0]          dur_q;
  logic [7:0]          dur_d;
  logic [6:0]          src_q;
  logic [6:0]          src_d;
  logic [7:0]          cnt_q;
  logic [7:0]          cnt_d;
  logic [7:0]          rdata_d;
  logic                irq_d;
  logic                tick;
  med_pkg::med_state_t state_q;
  med_pkg::med_state_t state_d;

  // ==========================================
  // address match, shared by write and read decode
  function automatic logic addr_is(
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    addr_is = (addr == ofs);
  endfunction

  // ==========================================
  // address decode
  wire sel_cfg = addr_is(bus_in.addr, med_pkg::MED_CFG_OFS);
  wire sel_src = addr_is(bus_in.addr, med_pkg::MED_SRC_OFS);
  wire sel_ths = addr_is(bus_in.addr, med_pkg::MED_THS_OFS);
  wire sel_dur = addr_is(bus_in.addr, med_pkg::MED_DUR_OFS);
  wire wr_cfg  = bus_in.wr && sel_cfg;
  wire wr_ths  = bus_in.wr && sel_ths;
  wire wr_dur  = bus_in.wr && sel_dur;
  wire rd_src  = bus_in.rd && sel_src;

  // ==========================================
  // configuration fields
  wire       latch_request_enable     = cfg_q[med_pkg::MED_LIR_BIT];
  wire       event_combine_select     = cfg_q[med_pkg::MED_COMB_BIT];
  wire       counter_decrement_select = ths_q[med_pkg::MED_COUNTER_DECREMENT_SELECT_BIT];
  wire [5:0] enables                  = cfg_q[5:0];
  wire [5:0] hits                     = axis_event_in & enables;

  // ==========================================
  // event combination
  wire       any_enabled = (enables != 6'h00);
  wire       or_cond     = (hits != 6'h00);
  wire       and_cond    = ((axis_event_in | ~enables) == 6'h3f);
  wire       cond        = any_enabled && (event_combine_select ? and_cond : or_cond);
  wire       at_limit    = (cnt_q >= dur_q);
  wire       confirmed   = cond && at_limit;
  wire       frozen      = latch_request_enable && (state_q == med_pkg::MED_FIRED);
  // latched read, or leaving latch mode, releases
  wire       release_src = rd_src || !latch_request_enable;

  // ==========================================
  // counter steps
  wire       step     = ce_in && tick && !frozen;
  wire       at_zero  = (cnt_q == 8'h00);
  wire [7:0] cnt_up   = at_limit ? dur_q : cnt_q + 8'h01;
  wire [7:0] cnt_down = at_zero ? 8'h00 : cnt_q - 8'h01;

  // ==========================================
  // read data select
  assign rdata_d = sel_cfg ? cfg_q :
                   sel_src ? {1'b0, src_q} :
                   sel_ths ? ths_q :
                   sel_dur ? dur_q : 8'h00;

  // ==========================================
  // register next values
  assign cfg_d = wr_cfg ? bus_in.wdata : cfg_q;
  assign ths_d = wr_ths ? bus_in.wdata : ths_q;
  assign dur_d = wr_dur ? bus_in.wdata : dur_q;

  // ==========================================
  // sample tick
  // rate picks the tick period
  med_tick #(
    .FAST_CYC (FAST_CYC),
    .SLOW_CYC (SLOW_CYC)
  ) u_tick (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .fast_in    (fast_rate_in),
    .tick_out   (tick)
  );

  // ==========================================
  // duration counter next value
  // step and saturate
  always_comb
  begin
    cnt_d = cnt_q;
    if (step)
    begin
      if (cond)
        cnt_d = cnt_up;
      else if (counter_decrement_select)
        cnt_d = cnt_down;
      else
        cnt_d = 8'h00;
    end
  end

  // ==========================================
  // source and interrupt next values
  always_comb
  begin
    state_d = state_q;
    src_d   = src_q;
    irq_d   = motion_interrupt_out;
    case (state_q)
      med_pkg::MED_IDLE:
      begin
        src_d = {confirmed, hits};
        irq_d = confirmed;
        if (confirmed && latch_request_enable)
          state_d = med_pkg::MED_FIRED;
      end
      med_pkg::MED_FIRED:
      begin
        if (release_src)
        begin
          src_d   = 7'h00;
          irq_d   = 1'b0;
          state_d = med_pkg::MED_IDLE;
        end
      end
      default:
        state_d = med_pkg::MED_IDLE;
    endcase
  end

  // ==========================================
  // configuration registers
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      cfg_q <= med_pkg::MED_CFG_RST;
      ths_q <= med_pkg::MED_THS_RST;
      dur_q <= med_pkg::MED_DUR_RST;
    end
    else if (ce_in)
    begin
      cfg_q <= cfg_d;
      ths_q <= ths_d;
      dur_q <= dur_d;
    end
  end

  // ==========================================
  // read data register
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      rdata_out <= 8'h00;
    else if (ce_in && bus_in.rd)
      rdata_out <= rdata_d;
  end

  // ==========================================
  // duration counter register
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      cnt_q <= 8'h00;
    else if (ce_in)
      cnt_q <= cnt_d;
  end

  // ==========================================
  // source, state and interrupt registers
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      state_q              <= med_pkg::MED_IDLE;
      src_q                <= 7'h00;
      motion_interrupt_out <= 1'b0;
    end
    else if (ce_in)
    begin
      state_q              <= state_d;
      src_q                <= src_d;
      motion_interrupt_out <= irq_d;
    end
  end

  // ==========================================
  // threshold output
  assign threshold_value_out = ths_q[6:0];
  // source never written; no write path to src_q
endmodule

// [tb/med_top_asserts.sv]
// port assertions for the motion event block
// assumes it is bound onto med_top
module med_chk (
  input wire logic              sys_clk_in,
  input wire logic              rst_in,
  input wire logic              ce_in,
  input wire med_pkg::med_bus_t bus_in,
  input wire logic [5:0]        axis_event_in,
  input wire logic [7:0]        rdata_out,
  input wire logic [6:0]        threshold_value_out,
  input wire logic              motion_interrupt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cfg_q;
  wire        rd_w = ce_in && bus_in.rd;
  wire        srd  = rd_w && bus_in.addr == 8'h31;
  wire [5:0]  hit  = axis_event_in & cfg_q[5:0];
  wire        off  = cfg_q[7] ? hit != cfg_q[5:0] : hit == 6'h00;
  // ==========================================
  // config shadow
  always_ff @(posedge sys_clk_in)
    if (rst_in)
      cfg_q <= 8'h00;
    else if (ce_in && bus_in.wr && bus_in.addr == 8'h30)
      cfg_q <= bus_in.wdata;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  property p_ths_rst; $past(rst_in) |-> threshold_value_out == 7'h02; endproperty
  a_ths_rst: assert property (p_ths_rst) else $error("threshold reset");
  property p_ths_wr; ce_in && bus_in.wr && bus_in.addr == 8'h32 |=> threshold_value_out == $past(bus_in.wdata[6:0]);
  endproperty
  a_ths_wr: assert property (p_ths_wr) else $error("threshold write");
  property p_rd_clr; srd && cfg_q[6] |=> !motion_interrupt_out; endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("read clear");
  property p_hold; cfg_q[6] && motion_interrupt_out && !srd && !bus_in.wr |=> motion_interrupt_out; endproperty
  a_hold: assert property (p_hold) else $error("latch hold");
  property p_off; (ce_in && !cfg_q[6] && off && !bus_in.wr) [*2] |=> !motion_interrupt_out; endproperty
  a_off: assert property (p_off) else $error("combine off");
  property p_rise; $rose(motion_interrupt_out) |-> $past(|axis_event_in) || $past(|axis_event_in, 2); endproperty
  a_rise: assert property (p_rise) else $error("rise cause");
  property p_rd_hold; !rd_w |=> $stable(rdata_out); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read hold");
  property p_unmap; rd_w && bus_in.addr > 8'h33 |=> rdata_out == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule
bind med_top med_chk u_chk (.sys_clk_in, .rst_in, .ce_in, .bus_in, .axis_event_in,
  .rdata_out, .threshold_value_out, .motion_interrupt_out);

// [tb/med_host.sv]
// host model issuing one-cycle register strobes
// assumes the device clock is shared
module med_host (
  input  wire logic        clk_in,
  output med_pkg::med_bus_t bus_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus_out = '0;
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in) #1;
    bus_out = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_in) #1;
    bus_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

// [tb/testbench.sv]
// self-checking bench for med_top
// assumes med_host drives the register port
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, ce, fast, irq;
  logic [5:0] ev;
  logic [7:0] rd;
  logic [6:0] ths;
  med_pkg::med_bus_t bus;
  int mismatches, compares, t;
  med_host h (.clk_in(clk), .bus_out(bus));
  med_top #(.FAST_CYC(4), .SLOW_CYC(16)) dut (.sys_clk_in(clk), .rst_in(rst), .ce_in(ce), .bus_in(bus),
    .fast_rate_in(fast), .axis_event_in(ev), .rdata_out(rd), .threshold_value_out(ths), .motion_interrupt_out(irq));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_sim;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic dur_run(input logic f, input logic [7:0] d);
    int c;
    c = f ? 4 : 16;
    fast = f;
    h.acc(1, 8'h33, d);
    tk(40);
    ev = 6'h02;
    t = 0;
    while (irq !== 1'b1 && t < 2000)
    begin
      tk(1);
      t++;
    end
    chk(8'(t > (d - 1) * c && t <= d * c + 3), 8'h01);
    ev = 6'h00;
    h.acc(1, 8'h31, 8'hff);
    h.acc(0, 8'h31, 8'h00);
    chk(rd, 8'h42);
    chk({7'h0, irq}, 8'h00);
    h.acc(0, 8'h31, 8'h00);
    chk(rd, 8'h00);
  endtask
  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    #200000;
    mismatches++;
    end_sim();
  end
  initial
  begin
    rst = 1;
    ce = 1;
    fast = 1;
    ev = 0;
    t = $urandom(32'h2b1b5a6f);
    repeat (12) @(posedge clk);
    #1 rst = 0;
    chk({1'b0, ths}, 8'h02);
    h.acc(0, 8'h32, 8'h00);
    chk(rd, 8'h02);
    h.acc(0, 8'h34, 8'h00);
    chk(rd, 8'h00);
    t = $urandom;
    h.acc(1, 8'h32, 8'(t));
    chk({1'b0, ths}, {1'b0, 7'(t)});
    h.acc(1, 8'h32, 8'h02);
    ce = 0;
    h.acc(1, 8'h32, 8'h7f);
    chk({1'b0, ths}, 8'h02);
    ce = 1;
    h.acc(1, 8'h30, 8'h42);
    for (int i = 0; i < 4; i++)
      dur_run(i[0], 8'($urandom_range(9, 2)));
    h.acc(1, 8'h33, 8'h00);
    for (int m = 0; m < 2; m++)
    begin
      h.acc(1, 8'h30, {m[0], 7'h03});
      ev = 6'h01;
      tk(4);
      chk({7'h0, irq}, {7'h0, !m[0]});
    end
    repeat (60)
    begin
      ev = 6'($urandom);
      tk(1);
      chk({7'h0, irq}, {7'h0, ev[1:0] == 2'b11});
    end
    end_sim();
  end
endmodule
